// ==== verilog/adcc_trigger_ctrl.sv ====
// Sample/convert sequencer with selectable conversion trigger
module adcc_trigger_ctrl
  import adcc_pkg::*;
#(
  parameter int CONV_TADS = CONV_TADS_DEF,
  parameter int RES_W = 10
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Register port
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wr_data_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  output logic [DATA_W-1:0] rd_data_o,
  // Trigger sources
  input wire logic ext_irq_pin_i,
  input wire logic timer_match_i,
  input wire logic event3_i,
  // Converter core
  input wire logic [RES_W-1:0] adc_data_i,
  output logic sampling_o,
  output logic converting_o,
  output logic conv_start_o,
  output logic [RES_W-1:0] result_o,
  output logic result_wr_o,
  // Interrupt
  output logic irq_o
);

  localparam int CW = $clog2(CONV_TADS + 1);

  if (CONV_TADS < 1 || RES_W < 1 || RES_W > DATA_W) begin : g_bad_param
    $error("adcc_trigger_ctrl: CONV_TADS or RES_W out of range");
  end

  // Control fields
  logic en_reg;
  logic [SRC_W-1:0] src_reg;
  logic auto_reg;
  logic sample_reg;
  logic done_reg;
  logic [SAMPLE_COUNT_W-1:0] sample_count_reg;
  logic [DIV_W-1:0] div_reg;
  logic ext_fall_reg;
  logic [EVT_W-1:0] stat_reg;
  logic [EVT_W-1:0] mask_reg;
  logic [EVT_W-1:0] stat_next;

  // Sequencer
  adcc_state_t state_reg;
  logic busy_reg;
  logic [SAMPLE_COUNT_W-1:0] smp_cnt_reg;
  logic [CW-1:0] conv_cnt_reg;
  logic abort_reg;
  logic tad_tick;

  // Pin synchroniser and edge detect
  logic ext_meta_reg;
  logic ext_sync_reg;
  logic ext_prev_reg;
  logic ext_edge;

  // Decoded strobes
  logic wr_c1;
  logic wr_c3;
  logic wr_mask;
  logic rd_stat;
  logic en_off_wr;
  logic abort_now;
  logic cnt_hit;
  logic sw_trig;
  logic hw_fire;
  logic trig;
  logic conv_last;
  logic auto_now;

  // Source decoding, used by the sequencer through hw_fire; the checks decode sources themselves
  function automatic logic hw_trig(input logic [2:0] src,
                                   input logic ext_e,
                                   input logic tmr,
                                   input logic ev3,
                                   input logic cnt);
    case (src)
      SRC_EXT: hw_trig = ext_e;
      SRC_TIMER: hw_trig = tmr;
      SRC_EVT3: hw_trig = ev3;
      SRC_COUNT: hw_trig = cnt;
      default: hw_trig = 1'b0;
    endcase
  endfunction

  // Address decode of the register port
  always_comb begin
    wr_c1 = 1'b0;
    wr_c3 = 1'b0;
    wr_mask = 1'b0;
    rd_stat = 1'b0;
    if (wr_en_i && addr_i == ADDR_CTRL1) begin
      wr_c1 = 1'b1;
    end else if (wr_en_i && addr_i == ADDR_CTRL3) begin
      wr_c3 = 1'b1;
    end else if (wr_en_i && addr_i == ADDR_MASK) begin
      wr_mask = 1'b1;
    end
    if (rd_en_i && addr_i == ADDR_STAT) begin
      rd_stat = 1'b1;
    end
  end

  // Pin passes two flops before the edge detector looks at it
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ext_meta_reg <= 1'b0;
      ext_sync_reg <= 1'b0;
      ext_prev_reg <= 1'b0;
    end else begin
      ext_meta_reg <= ext_irq_pin_i;
      ext_sync_reg <= ext_meta_reg;
      ext_prev_reg <= ext_sync_reg;
    end
  end

  // Polarity bit picks the active edge
  assign ext_edge = ext_fall_reg ? (ext_prev_reg && !ext_sync_reg)
                                 : (!ext_prev_reg && ext_sync_reg);

  // Conversion clock ticks only while enabled
  adcc_tad_div #(
    .WIDTH(DIV_W)
  ) u_tad_div (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .run_i(en_reg),
    .div_i(div_reg),
    .tick_o(tad_tick)
  );

  // Trigger and abort terms
  assign en_off_wr = wr_c1 && !wr_data_i[EN_BIT];
  // An enabling write may also start sampling in that same cycle
  assign abort_now = wr_c1 ? !wr_data_i[EN_BIT] : !en_reg;
  assign auto_now = wr_c1 ? wr_data_i[AUTO_BIT] : auto_reg;
  // Zero count never fires; software keeps it nonzero
  assign cnt_hit = tad_tick && (sample_count_reg != '0)
                   && ({1'b0, smp_cnt_reg} + 6'h01 == {1'b0, sample_count_reg});
  assign sw_trig = wr_c1 && src_reg == SRC_SOFT && sample_reg
                   && !wr_data_i[SAMPLE_BIT];
  assign hw_fire = hw_trig(src_reg, ext_edge, timer_match_i, event3_i,
                           cnt_hit);
  assign trig = sw_trig || hw_fire;
  assign conv_last = tad_tick && conv_cnt_reg == CW'(CONV_TADS - 1);

  // Software-owned control fields; source changes are accepted any time
  // but are only safe while disabled
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      en_reg <= 1'b0;
      src_reg <= SRC_RST;
      auto_reg <= 1'b0;
    end else if (wr_c1) begin
      en_reg <= wr_data_i[EN_BIT];
      src_reg <= wr_data_i[SRC_LSB +: SRC_W];
      auto_reg <= wr_data_i[AUTO_BIT];
    end
  end

  // Timing fields and pin polarity
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sample_count_reg <= SAMPLE_COUNT_RST;
      div_reg <= DIV_RST;
      ext_fall_reg <= 1'b0;
    end else if (wr_c3) begin
      sample_count_reg <= wr_data_i[SAMPLE_COUNT_LSB +: SAMPLE_COUNT_W];
      div_reg <= wr_data_i[DIV_LSB +: DIV_W];
      ext_fall_reg <= wr_data_i[EXTF_BIT];
    end
  end

  // Sample/convert sequencer; abort outranks everything
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
      sample_reg <= 1'b0;
      done_reg <= 1'b0;
      busy_reg <= 1'b0;
      smp_cnt_reg <= '0;
      conv_cnt_reg <= '0;
      conv_start_o <= 1'b0;
      result_wr_o <= 1'b0;
      result_o <= '0;
      abort_reg <= 1'b0;
    end else begin
      conv_start_o <= 1'b0;
      result_wr_o <= 1'b0;
      abort_reg <= 1'b0;
      if (abort_now) begin
        // Result port untouched: last complete result stays visible
        if (state_reg == ST_CONVERT) begin
          abort_reg <= 1'b1;
        end
        state_reg <= ST_IDLE;
        sample_reg <= 1'b0;
        busy_reg <= 1'b0;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            // Manual set of the sample bit or auto mode starts sampling
            if ((wr_c1 && wr_data_i[SAMPLE_BIT]) || auto_now) begin
              state_reg <= ST_SAMPLE;
              sample_reg <= 1'b1;
              smp_cnt_reg <= '0;
            end
          end
          ST_SAMPLE: begin
            if (trig) begin
              state_reg <= ST_CONVERT;
              sample_reg <= 1'b0;
              done_reg <= 1'b0;
              busy_reg <= 1'b1;
              conv_cnt_reg <= '0;
              conv_start_o <= 1'b1;
            end else if (wr_c1 && !wr_data_i[SAMPLE_BIT]) begin
              // Manual stop in a hardware mode ends sampling only
              state_reg <= ST_IDLE;
              sample_reg <= 1'b0;
            end else if (tad_tick) begin
              smp_cnt_reg <= smp_cnt_reg + 1'b1;
            end
          end
          ST_CONVERT: begin
            if (conv_last) begin
              done_reg <= 1'b1;
              busy_reg <= 1'b0;
              result_wr_o <= 1'b1;
              result_o <= adc_data_i;
              if (auto_now) begin
                state_reg <= ST_SAMPLE;
                sample_reg <= 1'b1;
                smp_cnt_reg <= '0;
              end else begin
                state_reg <= ST_IDLE;
              end
            end else if (tad_tick) begin
              conv_cnt_reg <= conv_cnt_reg + 1'b1;
            end
          end
          default: begin
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end

  assign sampling_o = sample_reg;
  assign converting_o = busy_reg;

  // Sticky events; a new event in the clearing read survives it
  always_comb begin
    stat_next = rd_stat ? '0 : stat_reg;
    stat_next[EVT_DONE] = stat_next[EVT_DONE] | result_wr_o;
    stat_next[EVT_TRIG] = stat_next[EVT_TRIG] | conv_start_o;
    stat_next[EVT_ABORT] = stat_next[EVT_ABORT] | abort_reg;
  end

  // Status, mask and interrupt line
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      stat_reg <= '0;
      mask_reg <= MASK_RST;
      irq_o <= 1'b0;
    end else begin
      stat_reg <= stat_next;
      if (wr_mask) begin
        mask_reg <= wr_data_i[EVT_W-1:0];
      end
      irq_o <= |(stat_next & (wr_mask ? wr_data_i[EVT_W-1:0] : mask_reg));
    end
  end

  // Read data stand for exactly one cycle; unmapped reads give zero
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rd_data_o <= '0;
    end else if (!rd_en_i) begin
      rd_data_o <= '0;
    end else if (addr_i == ADDR_CTRL1) begin
      rd_data_o <= {en_reg, 7'h00, src_reg, 2'h0, auto_reg, sample_reg,
                    done_reg};
    end else if (addr_i == ADDR_CTRL3) begin
      rd_data_o <= {ext_fall_reg, 2'h0, sample_count_reg, div_reg};
    end else if (addr_i == ADDR_STAT) begin
      rd_data_o <= {13'h0000, stat_reg};
    end else if (addr_i == ADDR_MASK) begin
      rd_data_o <= {13'h0000, mask_reg};
    end else begin
      rd_data_o <= '0;
    end
  end

  // Checks beside the sequencer

  a_soft_trig_start: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (state_reg == ST_SAMPLE && sw_trig && !abort_now)
      |=> (converting_o && conv_start_o && !sampling_o))
    else $error("software clear of sample bit did not start conversion");

  a_manual_sample: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (state_reg == ST_IDLE && !abort_now && wr_c1 && wr_data_i[SAMPLE_BIT])
      |=> sampling_o)
    else $error("setting sample bit did not start sampling");

  a_auto_resample: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (state_reg == ST_CONVERT && conv_last && !abort_now && auto_now)
      |=> (sampling_o && done_reg && result_wr_o))
    else $error("auto mode did not resume sampling after conversion");

  a_auto_stops: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (state_reg == ST_CONVERT && conv_last && !abort_now && !auto_now)
      |=> (!sampling_o && !converting_o && done_reg)
      ##1 (!sampling_o || $past(wr_c1)))
    else $error("sampling restarted with auto mode off");

  a_count_trig: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (state_reg == ST_SAMPLE && src_reg == SRC_COUNT && cnt_hit
     && !abort_now) |=> conv_start_o)
    else $error("counted trigger missed its sample count");

  a_ext_trig: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (state_reg == ST_SAMPLE && src_reg == SRC_EXT && ext_edge
     && !abort_now) |=> conv_start_o)
    else $error("pin edge did not end sampling");

  a_timer_trig: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (state_reg == ST_SAMPLE && src_reg == SRC_TIMER && timer_match_i
     && !abort_now) |=> conv_start_o)
    else $error("timer match did not end sampling");

  a_reserved_quiet: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (src_reg inside {3'h4, 3'h5, 3'h6} && !wr_c1) |=> !conv_start_o)
    else $error("reserved source code produced a trigger");

  a_done_cleared: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    conv_start_o |-> (!done_reg && !sampling_o && converting_o))
    else $error("conversion start left done or sample bit set");

  a_abort_nowrite: assert property (
    @(posedge clk_sys_i) disable iff (rst_i)
    (converting_o && en_off_wr)
      |=> (!converting_o && !result_wr_o && !done_reg && abort_reg))
    else $error("disable during conversion wrote a result");

endmodule

// ==== verilog/adcc_pkg.sv ====
// Shared constants and types for the converter trigger control block
package adcc_pkg;

  // Register map (word index on the plain register port)
  localparam int ADDR_W = 4;
  localparam logic [3:0] ADDR_CTRL1 = 4'h0;
  localparam logic [3:0] ADDR_CTRL3 = 4'h1;
  localparam logic [3:0] ADDR_STAT = 4'h2;
  localparam logic [3:0] ADDR_MASK = 4'h3;
  localparam int DATA_W = 16;

  // First control register fields
  localparam int EN_BIT = 15;
  localparam int SRC_LSB = 5;
  localparam int SRC_W = 3;
  localparam int AUTO_BIT = 2;
  localparam int SAMPLE_BIT = 1;
  localparam int DONE_BIT = 0;

  // Third control register fields
  localparam int EXTF_BIT = 15;
  localparam int SAMPLE_COUNT_LSB = 8;
  localparam int SAMPLE_COUNT_W = 5;
  localparam int DIV_LSB = 0;
  localparam int DIV_W = 8;

  // Status and mask layout
  localparam int EVT_W = 3;
  localparam int EVT_DONE = 0;
  localparam int EVT_TRIG = 1;
  localparam int EVT_ABORT = 2;

  // Trigger source codes
  localparam logic [2:0] SRC_SOFT = 3'h0;
  localparam logic [2:0] SRC_EXT = 3'h1;
  localparam logic [2:0] SRC_TIMER = 3'h2;
  localparam logic [2:0] SRC_EVT3 = 3'h3;
  localparam logic [2:0] SRC_COUNT = 3'h7;

  // Values after reset and cycle counts
  localparam logic [2:0] SRC_RST = 3'h0;
  localparam logic [4:0] SAMPLE_COUNT_RST = 5'h00;
  localparam logic [7:0] DIV_RST = 8'h01;
  localparam logic [2:0] MASK_RST = 3'h0;
  localparam int CONV_TADS_DEF = 12;

  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SAMPLE,
    ST_CONVERT
  } adcc_state_t;

endpackage

// ==== verilog/adcc_tad_div.sv ====
// Conversion clock divider: one-cycle tick every div_i+1 system clocks
module adcc_tad_div
  import adcc_pkg::*;
#(
  parameter int WIDTH = DIV_W
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Control
  input wire logic run_i,
  input wire logic [WIDTH-1:0] div_i,
  // Tick out
  output logic tick_o
);

  if (WIDTH < 1) begin : g_bad_width
    $error("adcc_tad_div: WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] cnt_reg;

  // Free count while running; restarts from zero so the first tick after
  // enable comes a full period later
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg <= '0;
      tick_o <= 1'b0;
    end else if (!run_i) begin
      cnt_reg <= '0;
      tick_o <= 1'b0;
    end else if (cnt_reg >= div_i) begin
      cnt_reg <= '0;
      tick_o <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
      tick_o <= 1'b0;
    end
  end

endmodule

// ==== verification/adcc_testbench.sv ====
// Self-checking bench for the converter trigger sequencer
module testbench import adcc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  // Short conversion keeps the run brief yet leaves room to abort
  localparam int CONV = 6;
  typedef struct {logic [3:0] addr; logic [15:0] exp;} adcc_note_t;

  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic [ADDR_W-1:0] addr_i = '0;
  logic [DATA_W-1:0] wr_data_i = '0;
  logic wr_en_i = 1'b0;
  logic rd_en_i = 1'b0;
  logic ext_irq_pin_i = 1'b0;
  logic timer_match_i = 1'b0;
  logic event3_i = 1'b0;
  logic [9:0] adc_data_i = '0;
  logic [DATA_W-1:0] rd_data_o;
  logic sampling_o;
  logic converting_o;
  logic conv_start_o;
  logic result_wr_o;
  logic irq_o;
  logic [9:0] result_o;
  logic rd_seen_reg = 1'b0;
  adcc_note_t note;
  adcc_note_t rd_q[$];
  logic [9:0] res_q[$];
  logic [2:0] srcs [7] = '{3'h1, 3'h2, 3'h3, 3'h1, 3'h4, 3'h5, 3'h6};
  logic pol;
  int err_total = 0;
  int tests_run = 0;
  int seed = 32'hCC88;
  int c;
  int starts;
  int p [2];

  adcc_trigger_ctrl #(.CONV_TADS(CONV), .RES_W(10)) uut (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .addr_i(addr_i),
    .wr_data_i(wr_data_i),
    .wr_en_i(wr_en_i),
    .rd_en_i(rd_en_i),
    .rd_data_o(rd_data_o),
    .ext_irq_pin_i(ext_irq_pin_i),
    .timer_match_i(timer_match_i),
    .event3_i(event3_i),
    .adc_data_i(adc_data_i),
    .sampling_o(sampling_o),
    .converting_o(converting_o),
    .conv_start_o(conv_start_o),
    .result_o(result_o),
    .result_wr_o(result_wr_o),
    .irq_o(irq_o)
  );

  // Clock generator
  initial begin
    forever #20 clk_sys_i = ~clk_sys_i;
  end

  task automatic chk(input string name, input logic [15:0] exp, got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic finish_test();
    if (err_total == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // One-cycle register write
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    wr_en_i <= 1'b1;
    addr_i <= a;
    wr_data_i <= d;
    @(posedge clk_sys_i);
    wr_en_i <= 1'b0;
  endtask

  // One-cycle register read; the answer is judged by the monitor
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk_sys_i);
    rd_en_i <= 1'b1;
    addr_i <= a;
    rd_q.push_back('{a, e});
    @(posedge clk_sys_i);
    rd_en_i <= 1'b0;
  endtask

  // Bounded wait for a conversion start or a result write
  task automatic wait_evt(input bit res, output int n);
    n = 0;
    do begin
      @(negedge clk_sys_i);
      n++;
    end while ((res ? result_wr_o : conv_start_o) !== 1'b1 && n < 300);
    if (n >= 300) chk("event wait", 16'h1, 16'h0);
  endtask

  // New converter sample, noted as the next expected result
  task automatic new_data();
    logic [9:0] d;
    d = 10'($random(seed));
    adc_data_i <= d;
    res_q.push_back(d);
  endtask

  // Reserved codes get the pin, timer and event3 triggers at once to prove none is taken
  task automatic fire(input logic [2:0] src, input logic pl);
    @(posedge clk_sys_i);
    ext_irq_pin_i <= (src == SRC_EXT || src > 3'h3) ? ~pl : pl;
    timer_match_i <= (src == SRC_TIMER || src > 3'h3);
    event3_i <= (src == SRC_EVT3 || src > 3'h3);
    @(posedge clk_sys_i);
    timer_match_i <= 1'b0;
    event3_i <= 1'b0;
  endtask

  // Monitor: read answers and results meet the oldest note
  always @(posedge clk_sys_i) rd_seen_reg <= rd_en_i;
  always @(negedge clk_sys_i) begin
    if (rd_seen_reg) begin
      if (rd_q.size() == 0) chk("unexpected read", 16'h0, 16'h1);
      else begin
        note = rd_q.pop_front();
        chk($sformatf("read addr %h", note.addr), note.exp, rd_data_o);
      end
    end
    if (result_wr_o === 1'b1) begin
      if (res_q.size() == 0) chk("stray result", 16'h0, 16'h1);
      else chk("result", {6'h0, res_q.pop_front()}, {6'h0, result_o});
    end
  end

  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #1000000;
    err_total++;
    finish_test();
  end

  initial begin
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    // Reset values, unmapped space, tick every clock
    rd(ADDR_CTRL1, 16'h0000);
    rd(ADDR_CTRL3, {8'h00, DIV_RST});
    rd(ADDR_MASK, 16'h0000);
    wr(4'hF, 16'hFFFF);
    rd(4'hF, 16'h0000);
    wr(ADDR_CTRL3, 16'h0000);
    rd(ADDR_CTRL3, 16'h0000);
    // Manual sampling, software conversion start
    new_data();
    wr(ADDR_CTRL1, 16'h8002);
    repeat (2) @(negedge clk_sys_i);
    chk("sampling", 16'h1, {15'h0, sampling_o});
    rd(ADDR_CTRL1, 16'h8002);
    wr(ADDR_CTRL1, 16'h8000);
    wait_evt(0, c);
    chk("sample at start", 16'h0, {15'h0, sampling_o});
    chk("converting", 16'h1, {15'h0, converting_o});
    rd(ADDR_CTRL1, 16'h8000);
    wait_evt(1, c);
    rd(ADDR_CTRL1, 16'h8001);
    rd(ADDR_STAT, 16'h0003);
    // Disable in mid-conversion: no result, done stays low
    wr(ADDR_CTRL1, 16'h8002);
    wr(ADDR_CTRL1, 16'h8000);
    wait_evt(0, c);
    wr(ADDR_CTRL1, 16'h0000);
    repeat (3) @(negedge clk_sys_i);
    chk("abort", 16'h0, {15'h0, converting_o});
    repeat (20) @(negedge clk_sys_i);
    rd(ADDR_CTRL1, 16'h0000);
    rd(ADDR_STAT, 16'h0006);
    // Interrupt masked, then unmasked, then cleared by reading status
    wr(ADDR_CTRL1, 16'h8002);
    new_data();
    wr(ADDR_CTRL1, 16'h8000);
    wait_evt(1, c);
    repeat (3) @(negedge clk_sys_i);
    chk("irq masked", 16'h0, {15'h0, irq_o});
    wr(ADDR_MASK, 16'h0001);
    repeat (2) @(negedge clk_sys_i);
    chk("irq unmasked", 16'h1, {15'h0, irq_o});
    rd(ADDR_MASK, 16'h0001);
    rd(ADDR_STAT, 16'h0003);
    repeat (3) @(negedge clk_sys_i);
    chk("irq cleared", 16'h0, {15'h0, irq_o});
    // Auto sampling with software clears; each gap holds a conversion
    wr(ADDR_CTRL1, 16'h8004);
    for (int k = 0; k < 2; k++) begin
      repeat (3) @(negedge clk_sys_i);
      chk("soft auto sampling", 16'h1, {15'h0, sampling_o});
      new_data();
      wr(ADDR_CTRL1, 16'h8004);
      wait_evt(0, c);
      chk("soft auto start", 16'h1, {15'h0, converting_o});
      wait_evt(1, c);
    end
    wr(ADDR_CTRL1, 16'h0000);
    // Event sources, both pin polarities, then the reserved codes
    for (int k = 0; k < 7; k++) begin
      pol = (k == 3);
      @(posedge clk_sys_i);
      ext_irq_pin_i <= pol;
      wr(ADDR_CTRL1, 16'h0000);
      wr(ADDR_CTRL3, {pol, 15'h0});
      wr(ADDR_CTRL1, 16'h8002 | (16'(srcs[k]) << SRC_LSB));
      repeat (6) @(negedge clk_sys_i);
      chk("wait trigger", 16'h1, {15'h0, sampling_o});
      if (srcs[k] < 3'h4) new_data();
      fire(srcs[k], pol);
      if (srcs[k] < 3'h4) begin
        wait_evt(0, c);
        chk("start delay", 16'h1, {15'h0, c <= 8});
        chk("sample cleared", 16'h0, {15'h0, sampling_o});
        wait_evt(1, c);
      end else begin
        starts = 0;
        repeat (15) @(negedge clk_sys_i) starts += conv_start_o;
        chk("reserved start", 16'h0, 16'(starts));
      end
    end
    // Automatic sampling paced by the timer match
    wr(ADDR_CTRL1, 16'h0000);
    wr(ADDR_CTRL1, 16'h8044);
    for (int k = 0; k < 2; k++) begin
      repeat (4) @(negedge clk_sys_i);
      chk("auto sampling", 16'h1, {15'h0, sampling_o});
      new_data();
      fire(SRC_TIMER, 1'b0);
      wait_evt(0, c);
      wait_evt(1, c);
    end
    // Counted trigger with auto: period grows by the count step
    for (int k = 0; k < 2; k++) begin
      wr(ADDR_CTRL1, 16'h0000);
      wr(ADDR_CTRL3, 16'(5 + 3 * k) << SAMPLE_COUNT_LSB);
      new_data();
      wr(ADDR_CTRL1, 16'h80E4);
      wait_evt(0, c);
      res_q.push_back(adc_data_i);
      wait_evt(0, p[k]);
      wait_evt(1, c);
      if (k == 1) begin
        wr(ADDR_CTRL1, 16'h80E2);
        res_q.push_back(adc_data_i);
        wait_evt(1, c);
        repeat (5) @(negedge clk_sys_i);
        chk("no restart", 16'h0, {15'h0, sampling_o});
      end
    end
    chk("count step", 16'h3, 16'(p[1] - p[0]));
    wr(ADDR_CTRL1, 16'h0000);
    repeat (4) @(negedge clk_sys_i);
    finish_test();
  end
endmodule
